// *** host_cpu_sideband_control.sv ***
`timescale 1ns/100ps
// Overview of operation
// - track up to four outstanding host bus transactions in an in-order queue
// - assert block-next-request when the queue is nearly full
// - keep block-next-request asserted until the queue starts draining
// - merge successive processor writes to PCI memory into one burst
// - combine only back-to-back posted processor-to-PCI writes on ascending dwords
// - processor writes to DRAM pass as plain DRAM writes, never merged
// - address bit 20 mask low only when fast gate and keyboard gate are zero
// - coprocessor error handling starts only while its enable bit is set; a disable drops line 13 only
// - enabled, an fpu error going active raises internal interrupt line 13
// - clear port write drops line 13 unless an fpu error rises in that cycle, and asserts ignore-error
// - ignore-error holds until fpu error goes inactive, never without it
// - disabled, no line 13 from fpu error and no ignore-error on clear
// - an init event while init is high drives init low for exactly 16 clocks
// - a shutdown special cycle on the host bus triggers init
// - fast gate port write taking soft init bit from 0 to 1 triggers init
// - reset port write raising system reset while cpu-only reset was 0 inits
// - keyboard reset request going low inits; rearmed only after it is high
// - nmi from pci system error or isa channel check when enabled
// - smi is active low, clocked, driven by enabled hardware or software events
// - special cycle byte enables 0000 0001 mean shutdown
module host_cpu_sideband_control
	import host_cpu_sideband_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ioq_req_start,
	input  wire logic        ioq_resp_done,
	output logic             block_next_request_n,
	input  wire logic        special_cycle_valid,
	input  wire logic [7:0]  special_cycle_be,
	input  wire logic        cpu_wr_valid,
	input  wire logic        cpu_wr_to_dram,
	input  wire logic [31:0] cpu_wr_addr,
	input  wire logic [31:0] cpu_wr_data,
	input  wire logic [3:0]  cpu_wr_be,
	output logic             cpu_wr_ready,
	output logic             pci_wr_valid,
	output logic             pci_wr_first,
	output logic             pci_wr_last,
	output logic      [31:0] pci_wr_addr,
	output logic      [31:0] pci_wr_data,
	output logic      [3:0]  pci_wr_be,
	input  wire logic        pci_wr_ready,
	output logic             dram_wr_valid,
	output logic      [31:0] dram_wr_addr,
	output logic      [31:0] dram_wr_data,
	output logic      [3:0]  dram_wr_be,
	input  wire logic        dram_wr_ready,
	input  wire logic        kbc_addr20_gate_in,
	output logic             addr_bit20_mask_out_n,
	input  wire logic        fpu_error_in_n,
	output logic             fpu_irq_line,
	output logic             ignore_fpu_error_out_n,
	output logic             init_out_n,
	input  wire logic        kbc_reset_request_in_n,
	input  wire logic        pci_serr_in_n,
	input  wire logic        isa_channel_check_in_n,
	output logic             nmi_out,
	input  wire logic        smi_event_in,
	output logic             sys_mgmt_irq_out_n
);

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [PIN_N-1:0] sync1_r;
	logic [PIN_N-1:0] sync2_r;
	wire  [PIN_N-1:0] pins_raw = {isa_channel_check_in_n, pci_serr_in_n,
		kbc_reset_request_in_n, fpu_error_in_n, kbc_addr20_gate_in};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end

	// ****************************************************************
	// apb slave
	// ****************************************************************
	logic [CT_W-1:0] ctrl_r;
	logic [1:0]      fast_gate_r;
	logic [2:1]      reset_ctl_r;
	logic            smi_stat_r;
	logic [31:0]     prdata_r;
	logic [31:0]     status_w;

	wire setup    = psel & ~penable;
	wire access   = psel & penable;
	wire sel_ctrl = (paddr == OFS_CTRL);
	wire sel_fast = (paddr == OFS_FAST_GATE);
	wire sel_rst  = (paddr == OFS_RESET_CTL);
	wire sel_fclr = (paddr == OFS_FPU_CLEAR);
	wire sel_stat = (paddr == OFS_STATUS);
	wire sel_smi  = (paddr == OFS_SMI_STAT);
	wire hit      = sel_ctrl | sel_fast | sel_rst | sel_fclr | sel_stat
		| sel_smi;
	wire wr_lo    = access & pwrite & pstrb[0];
	wire wr_ctrl  = wr_lo & sel_ctrl;
	wire wr_fast  = wr_lo & sel_fast;
	wire wr_rst   = wr_lo & sel_rst;
	wire wr_smi   = wr_lo & sel_smi;
	// the clear port acts on any write, whatever its data or strobes
	wire wr_fclr  = access & pwrite & sel_fclr;

	wire [31:0] rd_mux =
		sel_ctrl ? {27'h0, ctrl_r} :
		sel_fast ? {30'h0, fast_gate_r} :
		sel_rst  ? {29'h0, reset_ctl_r, 1'b0} :
		sel_stat ? status_w :
		sel_smi  ? {31'h0, smi_stat_r} : 32'h0;

	// read data is caught in the setup cycle so the access phase needs no wait
	assign pready  = access;
	assign pslverr = access & ~hit;
	assign prdata  = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_r <= 32'h0;
		else if (setup)
			prdata_r <= pwrite ? 32'h0 : rd_mux;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r      <= CTRL_RST;
			fast_gate_r <= FAST_GATE_RST;
			reset_ctl_r <= RESET_CTL_RST;
		end else begin
			if (wr_ctrl)
				ctrl_r <= pwdata[CT_W-1:0];
			if (wr_fast)
				fast_gate_r <= pwdata[1:0];
			if (wr_rst)
				reset_ctl_r <= pwdata[2:1];
		end
	end

	// ****************************************************************
	// in-order queue and block-next-request
	// ****************************************************************
	logic [2:0] ioq_cnt_r;
	logic       bnr_r;
	wire start_ok = ioq_req_start & (ioq_cnt_r != IOQ_DEPTH);
	wire done_ok  = ioq_resp_done & (ioq_cnt_r != 3'h0);
	wire [2:0] ioq_cnt_nxt = ioq_cnt_r + {2'h0, start_ok}
		- {2'h0, done_ok};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ioq_cnt_r <= 3'h0;
			bnr_r     <= 1'b0;
		end else begin
			ioq_cnt_r <= ioq_cnt_nxt;
			if (done_ok)
				bnr_r <= 1'b0;
			// only a new request re-blocks, so a retire stays a real release
			else if (start_ok && ioq_cnt_nxt >= IOQ_NEAR_FULL)
				bnr_r <= 1'b1;
		end
	end
	assign block_next_request_n = ~bnr_r;

	// ****************************************************************
	// processor write path: pci combining, dram pass-through
	// ****************************************************************
	// a burst only grows while writes arrive back to back on ascending
	// dwords; a gap closes it, trading burst length for no flush timer
	logic        hold_v_r;
	logic [31:0] hold_addr_r;
	logic [31:0] hold_data_r;
	logic [3:0]  hold_be_r;
	logic        pci_v_r;
	logic        pci_first_r;
	logic        pci_last_r;
	logic [31:0] pci_addr_r;
	logic [31:0] pci_data_r;
	logic [3:0]  pci_be_r;
	logic        in_burst_r;
	logic        dram_v_r;
	logic [31:0] dram_addr_r;
	logic [31:0] dram_data_r;
	logic [3:0]  dram_be_r;

	wire in_pci   = cpu_wr_valid & ~cpu_wr_to_dram;
	wire out_free = ~pci_v_r | pci_wr_ready;
	wire pci_room = ~hold_v_r | out_free;
	wire pci_acc  = in_pci & pci_room;
	wire [31:0] next_addr = hold_addr_r + WC_ADDR_STEP;
	wire seq      = cpu_wr_addr == next_addr;
	wire move     = hold_v_r & out_free;
	wire move_last = ~(pci_acc & seq);
	wire dram_room = ~dram_v_r | dram_wr_ready;
	wire dram_acc = cpu_wr_valid & cpu_wr_to_dram & dram_room;

	assign cpu_wr_ready = cpu_wr_to_dram ? dram_room : pci_room;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_v_r <= 1'b0;
		else
			hold_v_r <= pci_acc | (hold_v_r & ~move);
	end

	always_ff @(posedge pclk) begin
		if (pci_acc) begin
			hold_addr_r <= cpu_wr_addr;
			hold_data_r <= cpu_wr_data;
			hold_be_r   <= cpu_wr_be;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pci_v_r     <= 1'b0;
			pci_first_r <= 1'b0;
			pci_last_r  <= 1'b0;
			pci_addr_r  <= 32'h0;
			pci_data_r  <= 32'h0;
			pci_be_r    <= 4'h0;
			in_burst_r  <= 1'b0;
		end else if (move) begin
			pci_v_r     <= 1'b1;
			pci_first_r <= ~in_burst_r;
			pci_last_r  <= move_last;
			pci_addr_r  <= hold_addr_r;
			pci_data_r  <= hold_data_r;
			pci_be_r    <= hold_be_r;
			in_burst_r  <= ~move_last;
		end else if (pci_wr_ready) begin
			pci_v_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dram_v_r    <= 1'b0;
			dram_addr_r <= 32'h0;
			dram_data_r <= 32'h0;
			dram_be_r   <= 4'h0;
		end else if (dram_acc) begin
			dram_v_r    <= 1'b1;
			dram_addr_r <= cpu_wr_addr;
			dram_data_r <= cpu_wr_data;
			dram_be_r   <= cpu_wr_be;
		end else if (dram_wr_ready) begin
			dram_v_r <= 1'b0;
		end
	end

	assign pci_wr_valid  = pci_v_r;
	assign pci_wr_first  = pci_first_r;
	assign pci_wr_last   = pci_last_r;
	assign pci_wr_addr   = pci_addr_r;
	assign pci_wr_data   = pci_data_r;
	assign pci_wr_be     = pci_be_r;
	assign dram_wr_valid = dram_v_r;
	assign dram_wr_addr  = dram_addr_r;
	assign dram_wr_data  = dram_data_r;
	assign dram_wr_be    = dram_be_r;

	// ****************************************************************
	// address bit 20 mask
	// ****************************************************************
	logic addr_bit20_mask_out_n_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			addr_bit20_mask_out_n_r <= 1'b0;
		else
			addr_bit20_mask_out_n_r <= fast_gate_r[FG_A20] | sync2_r[PIN_A20];
	end
	assign addr_bit20_mask_out_n = addr_bit20_mask_out_n_r;

	// ****************************************************************
	// coprocessor error
	// ****************************************************************
	logic fpu_irq_r;
	logic ignore_fpu_error_out_r;
	logic fpu_error_in_prev_r;
	wire  fpu_en    = ctrl_r[CT_FPU_EN];
	wire  fpu_error_in_act  = ~sync2_r[PIN_FPU_ERROR_IN];
	wire  fpu_error_in_rise = fpu_error_in_act & ~fpu_error_in_prev_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fpu_error_in_prev_r <= 1'b0;
			fpu_irq_r   <= 1'b0;
			ignore_fpu_error_out_r     <= 1'b0;
		end else begin
			fpu_error_in_prev_r <= fpu_error_in_act;
			if (!fpu_en)
				fpu_irq_r <= 1'b0;
			else if (fpu_error_in_rise)
				fpu_irq_r <= 1'b1;
			else if (wr_fclr)
				fpu_irq_r <= 1'b0;
			if (!fpu_error_in_act)
				ignore_fpu_error_out_r <= 1'b0;
			else if (wr_fclr && fpu_en)
				ignore_fpu_error_out_r <= 1'b1;
		end
	end
	assign fpu_irq_line = fpu_irq_r;
	// gated with the live error level so a dropped error releases at once
	assign ignore_fpu_error_out_n = ~(ignore_fpu_error_out_r & fpu_error_in_act);

	// ****************************************************************
	// init pulse
	// ****************************************************************
	logic [4:0] init_cnt_r;
	logic       init_n_r;
	logic       kbc_armed_r;
	wire trig_shut = special_cycle_valid
		& (special_cycle_be == SHUTDOWN_BE);
	wire trig_soft = wr_fast & pwdata[FG_INIT]
		& ~fast_gate_r[FG_INIT];
	wire trig_rst  = wr_rst & pwdata[RC_SYS] & ~reset_ctl_r[RC_SYS]
		& ~reset_ctl_r[RC_CPU];
	wire trig_kbc  = kbc_armed_r & ~sync2_r[PIN_KBC_RESET_REQUEST_IN];
	wire init_trig = trig_shut | trig_soft | trig_rst | trig_kbc;
	wire [4:0] init_cnt_nxt =
		(init_cnt_r != 5'h0) ? init_cnt_r - 5'h1 :
		init_trig ? INIT_PULSE_CLKS : 5'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt_r  <= 5'h0;
			init_n_r    <= 1'b1;
			kbc_armed_r <= 1'b0;
		end else begin
			init_cnt_r  <= init_cnt_nxt;
			init_n_r    <= (init_cnt_nxt == 5'h0);
			if (sync2_r[PIN_KBC_RESET_REQUEST_IN])
				kbc_armed_r <= 1'b1;
			else if (trig_kbc)
				kbc_armed_r <= 1'b0;
		end
	end
	assign init_out_n = init_n_r;

	// ****************************************************************
	// nmi and smi
	// ****************************************************************
	logic nmi_r;
	logic smi_n_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_r      <= 1'b0;
			smi_stat_r <= 1'b0;
			smi_n_r    <= 1'b1;
		end else begin
			nmi_r <= (ctrl_r[CT_NMI_SERR] & ~sync2_r[PIN_SERR])
				| (ctrl_r[CT_NMI_IOCK] & ~sync2_r[PIN_IOCK]);
			// a new event beats a clear in the same cycle
			if (smi_event_in)
				smi_stat_r <= 1'b1;
			else if (wr_smi && pwdata[0])
				smi_stat_r <= 1'b0;
			smi_n_r <= ~((smi_stat_r & ctrl_r[CT_SMI_HW])
				| ctrl_r[CT_SMI_SW]);
		end
	end
	assign nmi_out            = nmi_r;
	assign sys_mgmt_irq_out_n = smi_n_r;

	// ****************************************************************
	// status image
	// ****************************************************************
	assign status_w = {22'h0, kbc_armed_r, ~smi_n_r, nmi_r,
		(init_cnt_r != 5'h0), ignore_fpu_error_out_r, fpu_irq_r, bnr_r, ioq_cnt_r};

endmodule // host_cpu_sideband_control

// *** host_cpu_sideband_pkg.sv ***
package host_cpu_sideband_pkg;
	// ****************************************************************
	// register map (byte addresses, paddr[7:0])
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_FAST_GATE = 8'h04;
	localparam logic [7:0] OFS_RESET_CTL = 8'h08;
	localparam logic [7:0] OFS_FPU_CLEAR = 8'h0c;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_SMI_STAT  = 8'h14;

	// ctrl fields
	localparam int CT_FPU_EN   = 0;
	localparam int CT_NMI_SERR = 1;
	localparam int CT_NMI_IOCK = 2;
	localparam int CT_SMI_HW   = 3;
	localparam int CT_SMI_SW   = 4;
	localparam int CT_W        = 5;
	localparam logic [CT_W-1:0] CTRL_RST = 5'h00;

	// fast gate port fields
	localparam int FG_INIT = 0;
	localparam int FG_A20  = 1;
	localparam logic [1:0] FAST_GATE_RST = 2'h0;

	// reset control port fields
	localparam int RC_SYS = 1;
	localparam int RC_CPU = 2;
	localparam logic [2:1] RESET_CTL_RST = 2'h0;

	// status fields
	localparam int ST_IOQ_LSB = 0;
	localparam int ST_BNR     = 3;
	localparam int ST_FPU_IRQ = 4;
	localparam int ST_IGNORE_FPU_ERROR_OUT   = 5;
	localparam int ST_INIT    = 6;
	localparam int ST_NMI     = 7;
	localparam int ST_SMI     = 8;
	localparam int ST_ARMED   = 9;

	// ****************************************************************
	// host bus queue, special cycles, init pulse, write combining
	// ****************************************************************
	localparam logic [2:0] IOQ_DEPTH     = 3'h4;
	localparam logic [2:0] IOQ_NEAR_FULL = 3'h3;
	localparam logic [7:0] SHUTDOWN_BE   = 8'h01;
	localparam logic [4:0] INIT_PULSE_CLKS = 5'h10;
	localparam logic [31:0] WC_ADDR_STEP = 32'h0000_0004;

	// ****************************************************************
	// synchronised pins
	// ****************************************************************
	localparam int PIN_A20  = 0;
	localparam int PIN_FPU_ERROR_IN = 1;
	localparam int PIN_KBC_RESET_REQUEST_IN = 2;
	localparam int PIN_SERR = 3;
	localparam int PIN_IOCK = 4;
	localparam int PIN_N    = 5;
	localparam logic [PIN_N-1:0] SYNC_RST = 5'h1e;
endpackage

// *** host_cpu_sideband_tail.sv ***
`timescale 1ns/100ps

// *** sideband_sva.sv ***
`timescale 1ns/100ps
module sideband_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ioq_req_start,
	input wire logic        ioq_resp_done,
	input wire logic        block_next_request_n,
	input wire logic        cpu_wr_valid,
	input wire logic        cpu_wr_to_dram,
	input wire logic [31:0] cpu_wr_addr,
	input wire logic        cpu_wr_ready,
	input wire logic        dram_wr_valid,
	input wire logic [31:0] dram_wr_addr,
	input wire logic        kbc_addr20_gate_in,
	input wire logic        addr_bit20_mask_out_n,
	input wire logic        fpu_error_in_n,
	input wire logic        ignore_fpu_error_out_n,
	input wire logic        init_out_n
);
	// ****************************************************************
	// queue depth and init pulse length, rebuilt from the pins
	// ****************************************************************
	logic [2:0] q_r;
	logic [5:0] low_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r   <= 3'h0;
			low_r <= 6'h00;
		end else begin
			q_r   <= q_r + 3'(ioq_req_start && q_r < 3'h4)
				- 3'(ioq_resp_done && q_r != 3'h0);
			low_r <= init_out_n ? 6'h00 : low_r + 6'h01;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_bnr_set;
		ioq_req_start && !ioq_resp_done && q_r == 3'h2
			|=> !block_next_request_n;
	endproperty
	a_bnr_set: assert property (p_bnr_set)
		else $error("bnr not asserted at three queued");
	property p_bnr_full;
		$fell(block_next_request_n) |-> q_r >= 3'h3;
	endproperty
	a_bnr_full: assert property (p_bnr_full)
		else $error("bnr asserted below three queued");
	property p_bnr_rel;
		ioq_resp_done && !ioq_req_start && !block_next_request_n
			|=> block_next_request_n;
	endproperty
	a_bnr_rel: assert property (p_bnr_rel)
		else $error("bnr kept after drain");
	property p_a20;
		kbc_addr20_gate_in [*4] |=> addr_bit20_mask_out_n;
	endproperty
	a_a20: assert property (p_a20) else $error("a20 masked");
	property p_ignore_fpu_error_out;
		!ignore_fpu_error_out_n |-> $past(!fpu_error_in_n, 2);
	endproperty
	a_ignore_fpu_error_out: assert property (p_ignore_fpu_error_out)
		else $error("ignore_fpu_error_out without fpu error");
	property p_init_len;
		$rose(init_out_n) |-> low_r == 6'd16;
	endproperty
	a_init_len: assert property (p_init_len)
		else $error("init pulse length");
	property p_init_max;
		low_r <= 6'd16;
	endproperty
	a_init_max: assert property (p_init_max)
		else $error("init pulse stretched");
	property p_dram;
		cpu_wr_valid && cpu_wr_ready && cpu_wr_to_dram
			|=> dram_wr_valid && dram_wr_addr == $past(cpu_wr_addr);
	endproperty
	a_dram: assert property (p_dram) else $error("dram write lost");
	c_bnr: cover property (!block_next_request_n);
	c_init: cover property ($rose(init_out_n));
	c_ignore_fpu_error_out: cover property (!ignore_fpu_error_out_n);
endmodule // sideband_sva

bind host_cpu_sideband_control sideband_sva u_sva (.*);

// *** cpu_bus_model.sv ***
`timescale 1ns/100ps
module cpu_bus_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic block_next_request_n,
	input  wire logic issue,
	input  wire logic retire,
	output logic      ioq_req_start,
	output logic      ioq_resp_done
);
	// ****************************************************************
	// host side of the in-order queue
	// ****************************************************************
	logic [2:0] out_r;
	logic [2:0] eff;
	assign eff = out_r + 3'(ioq_req_start) - 3'(ioq_resp_done);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_r         <= 3'h0;
			ioq_req_start <= 1'b0;
			ioq_resp_done <= 1'b0;
		end else begin
			out_r         <= eff;
			// stalls on bnr as a real host would, and never issues past four outstanding
			ioq_req_start <= issue && block_next_request_n
				&& eff < 3'h4;
			ioq_resp_done <= retire && eff != 3'h0;
		end
	end
endmodule // cpu_bus_model

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	import host_cpu_sideband_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        ioq_req_start, ioq_resp_done, block_next_request_n;
	logic        special_cycle_valid, cpu_wr_valid, cpu_wr_to_dram;
	logic        cpu_wr_ready, pci_wr_valid, pci_wr_first, pci_wr_last;
	logic        pci_wr_ready, dram_wr_valid, dram_wr_ready, issue, retire;
	logic        kbc_addr20_gate_in, addr_bit20_mask_out_n, fpu_irq_line;
	logic        fpu_error_in_n, ignore_fpu_error_out_n, init_out_n, nmi_out;
	logic        kbc_reset_request_in_n, pci_serr_in_n, smi_event_in, err;
	logic        isa_channel_check_in_n, sys_mgmt_irq_out_n, rdy_hi;
	logic [7:0]  paddr, special_cycle_be;
	logic [3:0]  pstrb, cpu_wr_be, pci_wr_be, dram_wr_be;
	logic [31:0] pwdata, prdata, cpu_wr_addr, cpu_wr_data, pci_wr_addr;
	logic [31:0] pci_wr_data, dram_wr_addr, dram_wr_data, rd, b;
	logic [31:0] qa[$], qd[$], qm[$];
	logic [1:0]  qf[$];
	int          num_errors = 0, tests_run = 0, n;
	host_cpu_sideband_control u_dut (.*);
	cpu_bus_model u_cpu (.*);
	// ****************************************************************
	// clock, far-side sinks and checking helpers
	// ****************************************************************
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		pci_wr_ready  <= rdy_hi | 1'($urandom % 2);
		dram_wr_ready <= 1'($urandom % 2);
		if (pci_wr_valid && pci_wr_ready) begin
			qa.push_back(pci_wr_addr);
			qd.push_back(pci_wr_data);
			qf.push_back({pci_wr_first, pci_wr_last});
		end
		if (dram_wr_valid && dram_wr_ready)
			qm.push_back(dram_wr_addr);
	end
	function automatic logic [31:0] dat(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	function automatic logic [1:0] fl(input int i, input int k);
		return {i == 0, i == k - 1};
	endfunction
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		chk("pready", 32'(pready), 32'h1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task spc(input logic [7:0] be);
		@(posedge pclk);
		{special_cycle_valid, special_cycle_be} <= {1'b1, be};
		@(posedge pclk);
		special_cycle_valid <= 1'b0;
	endtask
	task meas(input logic [31:0] exp);
		logic [31:0] c;
		c = 0;
		repeat (40) begin
			@(posedge pclk);
			if (init_out_n === 1'b0) c++;
		end
		chk("init low cycles", c, exp);
	endtask
	task wrs(input logic dr, input logic [31:0] a, input int k);
		int t;
		@(posedge pclk);
		for (int i = 0; i < k; i++) begin
			{cpu_wr_valid, cpu_wr_to_dram} <= {1'b1, dr};
			cpu_wr_addr <= a + 32'(4 * i);
			cpu_wr_data <= dat(a + 32'(4 * i));
			t = 0;
			do begin
				@(posedge pclk);
				t++;
			end while (cpu_wr_ready !== 1'b1 && t < 50);
			chk("cpu write accepted", 32'(cpu_wr_ready), 32'h1);
		end
		cpu_wr_valid <= 1'b0;
	endtask
	task chkq(input logic [31:0] a, input int k, input logic m);
		for (int i = 0; i < k && qa.size() != 0; i++) begin
			chk("pci addr", qa.pop_front(), a + 32'(4 * i));
			chk("pci data", qd.pop_front(), dat(a + 32'(4 * i)));
			if (m) chk("pci first last", 32'(qf.pop_front()), 32'(fl(i, k)));
			else void'(qf.pop_front());
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#300000;
		num_errors++;
		final_report;
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{psel, penable, pwrite, special_cycle_valid, cpu_wr_valid} = '0;
		{cpu_wr_to_dram, smi_event_in, kbc_addr20_gate_in, issue, retire} = '0;
		{fpu_error_in_n, kbc_reset_request_in_n, pci_serr_in_n} = '1;
		{isa_channel_check_in_n, rdy_hi, pci_wr_ready, dram_wr_ready} = '1;
		{paddr, special_cycle_be, pwdata, cpu_wr_addr, cpu_wr_data} = '0;
		{pstrb, cpu_wr_be} = 8'hff;
		presetn = 1'b0;
		void'($urandom(32'h87a1));
		tick(2);
		presetn <= 1'b1;
		apb(1'b0, OFS_CTRL, '0);
		chk("ctrl reset", rd, 32'(CTRL_RST));
		apb(1'b1, 8'h20, 32'h1);
		chk("unmapped error", 32'(err), 32'h1);
		chk("a20 mask", 32'(addr_bit20_mask_out_n), 32'h0);
		apb(1'b1, OFS_FAST_GATE, 32'h2);
		tick(3);
		chk("a20 mask", 32'(addr_bit20_mask_out_n), 32'h1);
		apb(1'b1, OFS_FAST_GATE, 32'h0);
		kbc_addr20_gate_in <= 1'b1;
		tick(5);
		chk("a20 mask", 32'(addr_bit20_mask_out_n), 32'h1);
		kbc_addr20_gate_in <= 1'b0;
		tick(5);
		chk("a20 mask", 32'(addr_bit20_mask_out_n), 32'h0);
		$display("test regs and a20 done");
		issue <= 1'b1;
		tick(12);
		chk("bnr full", 32'(block_next_request_n), 32'h0);
		issue <= 1'b0;
		retire <= 1'b1;
		tick(1);
		retire <= 1'b0;
		tick(3);
		chk("bnr drain", 32'(block_next_request_n), 32'h1);
		retire <= 1'b1;
		tick(8);
		retire <= 1'b0;
		apb(1'b0, OFS_STATUS, '0);
		chk("queue empty", 32'(rd[2:0]), 32'h0);
		$display("test queue done");
		for (int i = 0; i < 8; i++) begin
			spc(8'(i));
			meas(i == 1 ? 32'd16 : 32'd0);
		end
		fork
			meas(32'd16);
			begin
				spc(8'h01);
				tick(5);
				spc(8'h01);
			end
		join
		apb(1'b1, OFS_FAST_GATE, 32'h1);
		meas(32'd16);
		apb(1'b1, OFS_FAST_GATE, 32'h1);
		meas(32'd0);
		apb(1'b1, OFS_RESET_CTL, 32'h2);
		meas(32'd16);
		apb(1'b1, OFS_RESET_CTL, 32'h0);
		apb(1'b1, OFS_RESET_CTL, 32'h4);
		apb(1'b1, OFS_RESET_CTL, 32'h6);
		meas(32'd0);
		kbc_reset_request_in_n <= 1'b0;
		meas(32'd16);
		meas(32'd0);
		kbc_reset_request_in_n <= 1'b1;
		tick(6);
		kbc_reset_request_in_n <= 1'b0;
		meas(32'd16);
		kbc_reset_request_in_n <= 1'b1;
		$display("test init done");
		apb(1'b1, OFS_CTRL, 32'h1);
		fpu_error_in_n <= 1'b0;
		tick(6);
		chk("fpu irq", 32'(fpu_irq_line), 32'h1);
		apb(1'b1, OFS_FPU_CLEAR, '0);
		tick(2);
		chk("fpu irq", 32'(fpu_irq_line), 32'h0);
		chk("ignore_fpu_error_out", 32'(ignore_fpu_error_out_n), 32'h0);
		fpu_error_in_n <= 1'b1;
		tick(4);
		chk("ignore_fpu_error_out", 32'(ignore_fpu_error_out_n), 32'h1);
		apb(1'b1, OFS_CTRL, 32'h0);
		fpu_error_in_n <= 1'b0;
		tick(6);
		chk("fpu irq off", 32'(fpu_irq_line), 32'h0);
		apb(1'b1, OFS_FPU_CLEAR, '0);
		tick(2);
		chk("ignore_fpu_error_out off", 32'(ignore_fpu_error_out_n), 32'h1);
		fpu_error_in_n <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, OFS_CTRL, 32'h2 << i);
			{isa_channel_check_in_n, pci_serr_in_n} <= i ? 2'b01 : 2'b10;
			tick(5);
			chk("nmi", 32'(nmi_out), 32'h1);
			apb(1'b1, OFS_CTRL, 32'h0);
			tick(4);
			chk("nmi off", 32'(nmi_out), 32'h0);
			{isa_channel_check_in_n, pci_serr_in_n} <= 2'b11;
		end
		apb(1'b1, OFS_CTRL, 32'h10);
		tick(2);
		chk("smi sw", 32'(sys_mgmt_irq_out_n), 32'h0);
		apb(1'b1, OFS_CTRL, 32'h8);
		tick(2);
		chk("smi idle", 32'(sys_mgmt_irq_out_n), 32'h1);
		smi_event_in <= 1'b1;
		tick(1);
		smi_event_in <= 1'b0;
		tick(2);
		chk("smi hw", 32'(sys_mgmt_irq_out_n), 32'h0);
		apb(1'b1, OFS_SMI_STAT, 32'h1);
		tick(2);
		chk("smi clear", 32'(sys_mgmt_irq_out_n), 32'h1);
		$display("test fpu nmi smi done");
		b = $urandom & 32'h7fff_fff0;
		n = 2 + $urandom % 4;
		wrs(1'b0, b, n);
		wrs(1'b0, b + 32'(4 * n), 1);
		tick(20);
		chk("pci beats", 32'(qa.size()), 32'(n + 1));
		chkq(b, n, 1'b1);
		chkq(b + 32'(4 * n), 1, 1'b1);
		rdy_hi <= 1'b0;
		wrs(1'b0, b, 4);
		wrs(1'b1, b, 3);
		tick(30);
		chk("pci beats", 32'(qa.size()), 32'h4);
		chkq(b, 4, 1'b0);
		chk("dram writes", 32'(qm.size()), 32'h3);
		chk("dram addr", qm[2], b + 32'h8);
		$display("test write paths done");
		final_report;
	end
endmodule // tb_top
